/* shared/nand_host_pkg.sv */
/*
 * Package for the parallel flash host sequencer: command codes, pin group
 * structs, operation kinds, timing counts.
 * Assumes a 50 MHz system clock and a flash device on a multiplexed x8 bus.
 */
package nand_host_pkg;

   // ***************************************************************
   // Command codes
   // ***************************************************************
   localparam logic [7:0] CMD_READ_SETUP    = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM  = 8'h30;
   localparam logic [7:0] CMD_RAND_OUT      = 8'h05;
   localparam logic [7:0] CMD_RAND_OUT_CONF = 8'hE0;
   localparam logic [7:0] CMD_CACHE_READ    = 8'h31;
   localparam logic [7:0] CMD_CACHE_EXIT    = 8'h34;
   localparam logic [7:0] CMD_PROG_SETUP    = 8'h80;
   localparam logic [7:0] CMD_RAND_IN       = 8'h85;
   localparam logic [7:0] CMD_PROG_CONFIRM  = 8'h10;
   localparam logic [7:0] CMD_COPY_READ     = 8'h35;
   localparam logic [7:0] CMD_STATUS        = 8'h70;
   localparam logic [7:0] CMD_RESET         = 8'hFF;

   // ***************************************************************
   // Geometry and status fields
   // ***************************************************************
   localparam int PAGE_BYTES      = 2112;
   localparam int PAGE_WORDS      = 1056;
   localparam int MAX_PARTIAL     = 4;
   localparam int ST_FAIL_BIT     = 0;
   localparam int ST_ENGINE_IDLE  = 5;
   localparam int ST_CACHE_READY  = 6;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_NS          = 20;
   localparam int STROBE_NS       = 25;
   localparam int STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int WB_DELAY_NS     = 100;
   localparam int WB_DELAY_CYC    = (WB_DELAY_NS + CLK_NS - 1) / CLK_NS;

   // ***************************************************************
   // Operation kinds and request, pin and result structs
   // ***************************************************************
   typedef enum logic [2:0] {
      OP_READ       = 3'b000,
      OP_READ_NEXT  = 3'b001,
      OP_RAND_OUT   = 3'b010,
      OP_CACHE_READ = 3'b011,
      OP_CACHE_EXIT = 3'b100,
      OP_PROGRAM    = 3'b101,
      OP_COPY_BACK  = 3'b110,
      OP_RESET      = 3'b111
   } op_t;

   typedef struct packed {
      op_t         op;
      logic [11:0] column;
      logic [16:0] row;
      logic [16:0] target_row;
      logic [11:0] count;
      logic        five_cycles;
   } request_t;

   typedef struct packed {
      logic       cle;
      logic       ale;
      logic       ce_n;
      logic       we_n;
      logic       re_n;
      logic [7:0] dq_out;
      logic       dq_oe;
   } pins_t;

   typedef struct packed {
      logic       done;
      logic       fail;
      logic       refused;
      logic [7:0] status;
   } result_t;

endpackage

/* verilog/nand_strobe_gen.sv */
/*
 * Bus-cycle engine: one latched command, address or data cycle per start.
 * Assumes the caller holds the cycle inputs steady until done.
 */
`timescale 1ns/1ps
`default_nettype none
module nand_strobe_gen #(
   parameter int HOLD = nand_host_pkg::STROBE_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic       start,
   input  wire logic [1:0] kind,
   input  wire logic [7:0] data,
   output logic            we_n,
   output logic            re_n,
   output logic            cle,
   output logic            ale,
   output logic [7:0]      dq_out,
   output logic            dq_oe,
   output logic            done
);
   // Kind: 0 command, 1 address, 2 write data, 3 read data.
   logic [3:0] cnt;
   logic       phase;
   logic       busy;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         busy <= 1'b0; phase <= 1'b0; cnt <= 4'h0; done <= 1'b0;
         we_n <= 1'b1; re_n <= 1'b1; cle <= 1'b0; ale <= 1'b0;
         dq_out <= 8'h00; dq_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         // Done blocks a restart so the caller has one cycle to move to its next step.
         if (start && !busy && !done) begin
            busy   <= 1'b1; phase <= 1'b0; cnt <= 4'h0;
            cle    <= (kind == 2'd0);
            ale    <= (kind == 2'd1);
            dq_oe  <= (kind != 2'd3);
            dq_out <= data;
            we_n   <= (kind == 2'd3);
            re_n   <= (kind != 2'd3);
         end else if (busy) begin
            if (cnt == 4'(HOLD - 1)) begin
               cnt <= 4'h0;
               if (!phase) begin
                  // Rising edge of the strobe latches the cycle in the device.
                  phase <= 1'b1; we_n <= 1'b1; re_n <= 1'b1;
               end else begin
                  busy <= 1'b0; done <= 1'b1;
                  cle <= 1'b0; ale <= 1'b0; dq_oe <= 1'b0;
               end
            end else begin
               cnt <= cnt + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* verilog/nand_host_seq.sv */
/*
 * Host sequencer that drives a parallel flash over its multiplexed pins for
 * reads, cache reads, page programs and copy-back.
 * Assumes synchronous pin inputs and a user that waits for done.
 */
`timescale 1ns/1ps
`default_nettype none
module nand_host_seq (
   input  wire logic                   clk_sys,
   input  wire logic                   srst,
   input  wire logic                   req_valid,
   input  wire nand_host_pkg::request_t req,
   input  wire logic                   wr_valid,
   input  wire logic [7:0]             wr_data,
   input  wire logic [7:0]             dq_in,
   input  wire logic                   rb_in,
   output logic                        req_ready,
   output logic                        wr_ready,
   output logic                        rd_valid,
   output logic [7:0]                  rd_data,
   output nand_host_pkg::pins_t        pins,
   output nand_host_pkg::result_t      result
);
   // ***************************************************************
   // State
   // ***************************************************************
   typedef enum logic [3:0] {
      S_IDLE   = 4'b0000,
      S_CMD1   = 4'b0001,
      S_ADDR   = 4'b0010,
      S_DATA   = 4'b0011,
      S_CMD2   = 4'b0100,
      S_WAIT   = 4'b0101,
      S_READ   = 4'b0110,
      S_STAT_C = 4'b0111,
      S_STAT_R = 4'b1000,
      S_CB_CMD = 4'b1001,
      S_CB_ADR = 4'b1010,
      S_DONE   = 4'b1011
   } state_t;

   state_t                  state;
   nand_host_pkg::request_t cur;
   logic [2:0]              acnt;
   logic [11:0]             left;
   logic                    read_armed;
   logic                    in_cache;
   logic                    phase2;
   logic [3:0]              wb_cnt;
   logic [2:0]              partials;
   logic [16:0]             last_row;
   logic                    st_start;
   logic [1:0]              st_kind;
   logic [7:0]              st_data;
   logic                    st_done;
   logic                    s_we_n;
   logic                    s_re_n;
   logic                    s_cle;
   logic                    s_ale;
   logic [7:0]              s_dq;
   logic                    s_oe;
   logic [2:0]              nadr;
   logic [7:0]              abyte;
   logic [16:0]             arow;
   logic                    col_only;
   logic [7:0]              rd_hold;

   nand_strobe_gen nand_strobe_gen_inst (
      .clk_sys (clk_sys),
      .srst    (srst),
      .start   (st_start),
      .kind    (st_kind),
      .data    (st_data),
      .we_n    (s_we_n),
      .re_n    (s_re_n),
      .cle     (s_cle),
      .ale     (s_ale),
      .dq_out  (s_dq),
      .dq_oe   (s_oe),
      .done    (st_done)
   );

   // Random moves send two column cycles only; full ops 4 or 5.
   assign col_only = (cur.op == nand_host_pkg::OP_RAND_OUT) || phase2 && (cur.op == nand_host_pkg::OP_PROGRAM);
   assign nadr     = col_only ? 3'd2 : (cur.five_cycles ? 3'd5 : 3'd4);
   assign arow     = (state == S_CB_ADR) ? cur.target_row : cur.row;

   always_comb begin
      case (acnt)
         3'd0:    abyte = cur.column[7:0];
         3'd1:    abyte = {4'h0, cur.column[11:8]};
         3'd2:    abyte = arow[7:0];
         3'd3:    abyte = arow[15:8];
         default: abyte = {7'h00, arow[16]};
      endcase
   end

   // ***************************************************************
   // Strobe request selection
   // ***************************************************************
   always_comb begin
      st_start = 1'b0;
      st_kind  = 2'd0;
      st_data  = 8'h00;
      case (state)
         S_CMD1: begin
            st_start = 1'b1;
            case (cur.op)
               nand_host_pkg::OP_RAND_OUT:   st_data = nand_host_pkg::CMD_RAND_OUT;
               nand_host_pkg::OP_CACHE_EXIT: st_data = nand_host_pkg::CMD_CACHE_EXIT;
               nand_host_pkg::OP_RESET:      st_data = nand_host_pkg::CMD_RESET;
               nand_host_pkg::OP_PROGRAM:    st_data = phase2 ? nand_host_pkg::CMD_RAND_IN
                                                              : nand_host_pkg::CMD_PROG_SETUP;
               default:                      st_data = nand_host_pkg::CMD_READ_SETUP;
            endcase
         end
         S_ADDR, S_CB_ADR: begin
            st_start = 1'b1;
            st_kind  = 2'd1;
            st_data  = abyte;
         end
         S_DATA: begin
            // Wait out the taken pulse so the user can present the next byte.
            st_start = wr_valid && !wr_ready;
            st_kind  = 2'd2;
            st_data  = wr_data;
         end
         S_CMD2: begin
            st_start = 1'b1;
            case (cur.op)
               nand_host_pkg::OP_RAND_OUT:   st_data = nand_host_pkg::CMD_RAND_OUT_CONF;
               nand_host_pkg::OP_CACHE_READ: st_data = nand_host_pkg::CMD_CACHE_READ;
               nand_host_pkg::OP_PROGRAM:    st_data = nand_host_pkg::CMD_PROG_CONFIRM;
               nand_host_pkg::OP_COPY_BACK:  st_data = phase2 ? nand_host_pkg::CMD_PROG_CONFIRM
                                                              : nand_host_pkg::CMD_COPY_READ;
               default:                      st_data = nand_host_pkg::CMD_READ_CONFIRM;
            endcase
         end
         S_CB_CMD: begin
            st_start = 1'b1;
            st_data  = nand_host_pkg::CMD_RAND_IN;
         end
         S_STAT_C: begin
            st_start = 1'b1;
            st_data  = nand_host_pkg::CMD_STATUS;
         end
         S_READ, S_STAT_R: begin
            st_start = 1'b1;
            st_kind  = 2'd3;
         end
         default: ;
      endcase
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state <= S_IDLE; cur <= '0; acnt <= 3'd0; left <= 12'h000;
         read_armed <= 1'b0; in_cache <= 1'b0; phase2 <= 1'b0; wb_cnt <= 4'h0;
         req_ready <= 1'b0; wr_ready <= 1'b0; rd_valid <= 1'b0; rd_data <= 8'h00;
         result <= '0; partials <= 3'd0; last_row <= 17'h00000;
      end else begin
         rd_valid <= 1'b0; result.done <= 1'b0;
         req_ready <= (state == S_IDLE) && !req_valid;
         wr_ready <= (state == S_DATA) && st_done;
         case (state)
            S_IDLE: if (req_valid) begin
               cur <= req; acnt <= 3'd0; phase2 <= 1'b0; result.refused <= 1'b0;
               left <= (req.count == 12'h000) ? 12'h001 : req.count;
               // Random output is illegal in a cache read; exit only in one.
               if ((req.op == nand_host_pkg::OP_RAND_OUT && in_cache) ||
                   (req.op == nand_host_pkg::OP_CACHE_EXIT && !in_cache) ||
                   (req.op == nand_host_pkg::OP_PROGRAM && req.row == last_row &&
                    partials == 3'(nand_host_pkg::MAX_PARTIAL))) begin
                  result.refused <= 1'b1; result.done <= 1'b1;
               end else if (req.op == nand_host_pkg::OP_READ_NEXT && read_armed)
                  state <= S_CMD2;
               else if (req.op == nand_host_pkg::OP_READ_NEXT) begin
                  result.refused <= 1'b1; result.done <= 1'b1;
               end else
                  state <= S_CMD1;
            end
            S_CMD1: if (st_done) begin
               if (cur.op == nand_host_pkg::OP_CACHE_EXIT) begin
                  in_cache <= 1'b0; state <= S_WAIT;
               end else if (cur.op == nand_host_pkg::OP_RESET) begin
                  in_cache <= 1'b0; read_armed <= 1'b0; state <= S_WAIT;
               end else
                  state <= S_ADDR;
            end
            S_ADDR, S_CB_ADR: if (st_done) begin
               acnt <= acnt + 3'd1;
               if (acnt == nadr - 3'd1) begin
                  acnt <= 3'd0;
                  if (state == S_CB_ADR) state <= S_CMD2;
                  else if (cur.op == nand_host_pkg::OP_PROGRAM) state <= S_DATA;
                  else if (cur.op == nand_host_pkg::OP_RAND_OUT) state <= S_CMD2;
                  else state <= S_CMD2;
               end
            end
            S_DATA: if (st_done) begin
               left <= left - 12'h001;
               if (left == 12'h001) state <= S_CMD2;
            end
            S_CMD2: if (st_done) begin
               wb_cnt <= 4'h0;
               case (cur.op)
                  nand_host_pkg::OP_RAND_OUT: state <= S_READ;
                  nand_host_pkg::OP_CACHE_READ: begin
                     in_cache <= 1'b1; state <= S_WAIT;
                  end
                  nand_host_pkg::OP_PROGRAM: begin
                     partials <= (cur.row == last_row) ? partials + 3'd1 : 3'd1;
                     last_row <= cur.row; state <= S_WAIT;
                  end
                  default: begin
                     read_armed <= (cur.op != nand_host_pkg::OP_COPY_BACK);
                     state <= S_WAIT;
                  end
               endcase
            end
            S_WAIT: begin
               // Ready/busy lags the last strobe, so hold off before sampling.
               if (wb_cnt != 4'(nand_host_pkg::WB_DELAY_CYC)) wb_cnt <= wb_cnt + 4'h1;
               else if (rb_in) begin
                  case (cur.op)
                     nand_host_pkg::OP_PROGRAM: state <= S_STAT_C;
                     nand_host_pkg::OP_COPY_BACK: state <= phase2 ? S_STAT_C : S_CB_CMD;
                     nand_host_pkg::OP_RESET, nand_host_pkg::OP_CACHE_EXIT: begin
                        result.done <= 1'b1; state <= S_IDLE;
                     end
                     default: state <= S_READ;
                  endcase
               end
            end
            S_CB_CMD: if (st_done) begin
               phase2 <= 1'b1; state <= S_CB_ADR;
            end
            S_READ: if (st_done) begin
               rd_valid <= 1'b1; rd_data <= rd_hold;
               left <= left - 12'h001;
               if (left == 12'h001) begin
                  result.done <= 1'b1; state <= S_IDLE;
               end
            end
            S_STAT_C: if (st_done) state <= S_STAT_R;
            S_STAT_R: if (st_done) begin
               // Fail bit covers only cells that failed to reach zero.
               result.status <= rd_hold;
               result.fail <= rd_hold[nand_host_pkg::ST_FAIL_BIT];
               result.done <= 1'b1; read_armed <= 1'b0; state <= S_DONE;
            end
            S_DONE: state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // The device drives data only while the read strobe is low on the pins, so the
   // byte is held from the last cycle of that window, not taken at the end of the cycle.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_hold <= 8'h00;
      end else if (!pins.re_n) begin
         rd_hold <= dq_in;
      end
   end

   // ***************************************************************
   // Pin registers
   // ***************************************************************
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pins <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};
      end else begin
         pins.cle <= s_cle;
         pins.ale <= s_ale;
         pins.ce_n <= (state == S_IDLE);
         pins.we_n <= s_we_n;
         pins.re_n <= s_re_n;
         pins.dq_out <= s_dq;
         pins.dq_oe <= s_oe;
      end
   end
endmodule
`default_nettype wire

/* bench/nand_seq_monitor.sv */
/* Checker for the flash host sequencer pins and result.
   Assumes it is bound to nand_host_seq and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module nand_seq_monitor (
   input wire logic                   clk_sys,
   input wire logic                   srst,
   input wire logic                   rb_in,
   input wire logic                   rd_valid,
   input wire nand_host_pkg::pins_t   pins,
   input wire nand_host_pkg::result_t result
);
   // ********
   // Pin and result rules
   // ********
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_idle_after_reset: assert property ($fell(srst) |-> pins.ce_n && pins.we_n && pins.re_n && !pins.dq_oe)
      else $error("pins not idle after reset");
   a_latch_exclusive: assert property (!(pins.cle && pins.ale))
      else $error("both latch enables high");
   a_write_width: assert property ($fell(pins.we_n) |=> !pins.we_n ##1 pins.we_n ##1 pins.we_n)
      else $error("write strobe width wrong");
   a_latch_held: assert property ($rose(pins.we_n) |-> $stable(pins.dq_out) && $stable(pins.cle) && $past(pins.dq_oe))
      else $error("bus changed at write strobe rise");
   a_select_strobe: assert property (!pins.we_n || !pins.re_n |-> !pins.ce_n)
      else $error("strobe without chip select");
   a_no_contention: assert property (!pins.re_n |-> !pins.dq_oe)
      else $error("host drives bus during read strobe");
   a_read_width: assert property ($fell(pins.re_n) |-> rb_in ##1 !pins.re_n ##1 pins.re_n)
      else $error("read strobe while busy or wrong width");
   a_confirm_gap: assert property ($rose(pins.we_n) && pins.cle && pins.dq_out == 8'h30 |-> pins.re_n [*5])
      else $error("read strobe too soon after confirm");
   a_done_pulse: assert property (result.done |=> !result.done)
      else $error("done longer than one cycle");
   a_refuse_quiet: assert property ($rose(result.refused) |-> pins.ce_n && $past(pins.ce_n))
      else $error("refused request touched the bus");
   c_refused: cover property ($rose(result.refused));
   c_failed: cover property (result.done && result.fail);
   c_read: cover property (rd_valid);
endmodule
`default_nettype wire

/* bench/nand_dev_model.sv */
/* Behavioural x8 flash device for the host sequencer bench.
   Assumes the pins are registered on clk_sys; rb_in and dq_in change after edges. */
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
   parameter int LOAD = 20,
   parameter int LAT  = 6
) (
   input  wire logic                 clk_sys,
   input  wire nand_host_pkg::pins_t pins,
   input  wire logic                 fail_next,
   output logic [7:0]                dq_in,
   output logic                      rb_in
);
   logic [7:0]  cmd_q[$];
   logic [7:0]  addr_q[$];
   logic [7:0]  data_q[$];
   logic [7:0]  ab[0:4];
   logic [7:0]  setup = 8'hFF;
   logic [7:0]  last = 8'h5A;
   logic [7:0]  st;
   logic [11:0] col = 12'h000;
   logic        we_d = 1'b1, re_d = 1'b1, fail = 1'b0, have_read = 1'b0;
   logic        stat_mode = 1'b0;
   logic        in_cache = 1'b0, prog = 1'b0, loaded = 1'b0;
   int          busy = 0, bg = 0, acnt = 0;
   initial dq_in = 8'hA5;
   initial rb_in = 1'b1;
   // ********
   // Command decoder
   // ********
   task do_cmd(input logic [7:0] c);
      if (busy > 0 && c != 8'h70 && c != 8'hFF && !(c == 8'h34 && in_cache)) return;
      cmd_q.push_back(c);
      acnt = 0;
      stat_mode = 0;
      case (c)
         8'h00, 8'h05, 8'h80: begin
            setup = c;
            prog = (c == 8'h80);
            loaded = 0;
         end
         8'h30, 8'h31, 8'h35: if (setup == 8'h00 || (c == 8'h30 && have_read)) begin
            col = {ab[1][3:0], ab[0]};
            busy = (c == 8'h31) ? LAT : LOAD;
            bg = (c == 8'h31) ? LAT + LOAD : 0;
            in_cache = (c == 8'h31);
            loaded = (c == 8'h35);
            have_read = 1;
            setup = 8'h30;
         end
         8'hE0: if (setup == 8'h05 && !in_cache) col = {ab[1][3:0], ab[0]};
         8'h34: begin
            in_cache = 0;
            bg = 0;
         end
         8'h85: prog = 1;
         8'h10: if (prog && loaded) begin
            busy = LOAD;
            fail = fail_next;
            prog = 0;
            stat_mode = 1;
         end
         8'h70: stat_mode = 1;
         8'hFF: begin
            busy = 2;
            bg = 0;
            in_cache = 0;
            prog = 0;
         end
         default: ;
      endcase
   endtask
   // ********
   // Bus sampling
   // ********
   always @(posedge clk_sys) begin
      if (busy > 0) busy = busy - 1;
      if (bg > 0) bg = bg - 1;
      st = {1'b1, busy == 0, busy == 0 && bg == 0, 4'h0, fail};
      if (!pins.ce_n && pins.we_n && !we_d) begin
         if (pins.cle) do_cmd(pins.dq_out);
         else if (pins.ale) begin
            if (acnt < 5) begin
               ab[acnt] = pins.dq_out;
               addr_q.push_back(pins.dq_out);
            end
            acnt++;
         end else begin
            data_q.push_back(pins.dq_out);
            loaded = 1;
         end
      end
      // A released bus shows the inverse of the last byte so a stale sample cannot pass.
      if (!pins.ce_n && !pins.re_n && re_d) begin
         last = stat_mode ? st : (col[7:0] ^ 8'h5A);
         if (!stat_mode) col = col + 12'h001;
         dq_in <= last;
      end else if (pins.re_n && !re_d) dq_in <= ~last;
      we_d = pins.we_n;
      re_d = pins.re_n;
      rb_in <= (busy == 0);
   end
endmodule
`default_nettype wire

/* bench/test_nand_read_program_sequencer.sv */
/* Self-checking bench for the flash host sequencer.
   Assumes the behavioural device model on the far side and a 50 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module test_nand_read_program_sequencer;
   typedef logic [7:0] bq_t[$];
   logic                   clk_sys = 1'b0, srst = 1'b1, req_valid = 1'b0, wr_valid = 1'b0, fail_next = 1'b0;
   logic [7:0]             wr_data = 8'hC0;
   nand_host_pkg::request_t req = '0;
   logic                   req_ready, wr_ready, rd_valid, rb_in;
   logic [7:0]             rd_data, dq_in;
   nand_host_pkg::pins_t   pins;
   nand_host_pkg::result_t result;
   bq_t                    rd_q, none;
   int                     fails = 0, num_checks = 0;

   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (wr_ready === 1'b1) wr_data <= wr_data + 8'h01;
   always @(posedge clk_sys) if (rd_valid === 1'b1) rd_q.push_back(rd_data);

   nand_host_seq nand_host_seq_inst (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req(req),
      .wr_valid(wr_valid), .wr_data(wr_data), .dq_in(dq_in), .rb_in(rb_in), .req_ready(req_ready),
      .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .result(result));
   nand_dev_model nand_dev_model_inst (.clk_sys(clk_sys), .pins(pins), .fail_next(fail_next),
      .dq_in(dq_in), .rb_in(rb_in));

   // ********
   // Shared tasks
   // ********
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s exp=%h got=%h", name, exp, got);
      end
   endtask
   task automatic chk_q(input string name, input bq_t exp, input bq_t got);
      logic ok;
      ok = (got.size() == exp.size());
      foreach (exp[i]) if (ok && got[i] !== exp[i]) ok = 0;
      num_checks++;
      if (!ok) begin
         fails++;
         $display("mismatch %s exp=%p got=%p", name, exp, got);
      end
   endtask
   function automatic bq_t addr(input logic [11:0] c, input logic [16:0] r);
      return '{c[7:0], {4'h0, c[11:8]}, r[7:0], r[15:8], {7'h00, r[16]}};
   endfunction
   function automatic bq_t rd(input logic [11:0] c);
      return '{c[7:0] ^ 8'h5A, (c[7:0] + 8'h01) ^ 8'h5A, (c[7:0] + 8'h02) ^ 8'h5A};
   endfunction
   // Valid is offered for one edge while ready stands, so a request is never taken twice.
   task automatic run(input nand_host_pkg::op_t op, input logic [11:0] c, input logic [16:0] r);
      int k;
      nand_dev_model_inst.cmd_q.delete();
      nand_dev_model_inst.addr_q.delete();
      nand_dev_model_inst.data_q.delete();
      rd_q.delete();
      k = 0;
      while (req_ready !== 1'b1 && k < 50) begin @(posedge clk_sys); k++; end
      req <= '{op, c, r, r ^ 17'h00002, 12'h003, 1'b1};
      wr_data <= 8'hC0;
      wr_valid <= (op == nand_host_pkg::OP_PROGRAM);
      req_valid <= 1'b1;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      while (result.done !== 1'b1 && k < 20000) begin @(posedge clk_sys); k++; end
      wr_valid <= 1'b0;
      chk("request_done", 1, k < 20000);
      repeat (2) @(posedge clk_sys);
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_refuse();
      run(nand_host_pkg::OP_READ_NEXT, 12'h000, 17'h00000);
      chk("next_refused", 1, result.refused);
      chk_q("next_cmds", none, nand_dev_model_inst.cmd_q);
      run(nand_host_pkg::OP_CACHE_EXIT, 12'h000, 17'h00000);
      chk("exit_refused", 1, result.refused);
      chk_q("exit_cmds", none, nand_dev_model_inst.cmd_q);
   endtask
   task automatic t_read();
      run(nand_host_pkg::OP_READ, 12'h83E, 17'h1ABCD);
      chk_q("read_cmds", '{8'h00, 8'h30}, nand_dev_model_inst.cmd_q);
      chk_q("read_addr", addr(12'h83E, 17'h1ABCD), nand_dev_model_inst.addr_q);
      chk_q("read_data", rd(12'h83E), rd_q);
      run(nand_host_pkg::OP_READ_NEXT, 12'h000, 17'h1ABCE);
      chk_q("next_cmds", '{8'h30}, nand_dev_model_inst.cmd_q);
      run(nand_host_pkg::OP_RAND_OUT, 12'h010, 17'h1ABCE);
      chk_q("rand_cmds", '{8'h05, 8'hE0}, nand_dev_model_inst.cmd_q);
      chk_q("rand_addr", '{8'h10, 8'h00}, nand_dev_model_inst.addr_q);
      chk_q("rand_data", rd(12'h010), rd_q);
   endtask
   task automatic t_cache();
      run(nand_host_pkg::OP_CACHE_READ, 12'h000, 17'h00040);
      chk_q("cache_cmds", '{8'h00, 8'h31}, nand_dev_model_inst.cmd_q);
      chk_q("cache_addr", addr(12'h000, 17'h00040), nand_dev_model_inst.addr_q);
      chk_q("cache_data", rd(12'h000), rd_q);
      run(nand_host_pkg::OP_RAND_OUT, 12'h005, 17'h00040);
      chk("rand_refused", 1, result.refused);
      chk_q("rand_cmds", none, nand_dev_model_inst.cmd_q);
      run(nand_host_pkg::OP_CACHE_EXIT, 12'h000, 17'h00040);
      chk_q("exit_cmds", '{8'h34}, nand_dev_model_inst.cmd_q);
      chk("exit_refused", 0, result.refused);
   endtask
   task automatic t_program();
      for (int i = 0; i < 4; i++) begin
         fail_next <= (i == 3);
         run(nand_host_pkg::OP_PROGRAM, 12'h000, 17'h00155);
         chk_q("prog_cmds", '{8'h80, 8'h10, 8'h70}, nand_dev_model_inst.cmd_q);
         chk_q("prog_data", '{8'hC0, 8'hC1, 8'hC2}, nand_dev_model_inst.data_q);
         chk("prog_fail", i == 3, result.fail);
         chk("prog_status", 8'hE0 | (i == 3), result.status);
      end
      run(nand_host_pkg::OP_PROGRAM, 12'h000, 17'h00155);
      chk("fifth_refused", 1, result.refused);
      chk_q("fifth_cmds", none, nand_dev_model_inst.cmd_q);
   endtask
   task automatic t_copy();
      fail_next <= 1'b1;
      run(nand_host_pkg::OP_COPY_BACK, 12'h000, 17'h00020);
      chk_q("copy_cmds", '{8'h00, 8'h35, 8'h85, 8'h10, 8'h70}, nand_dev_model_inst.cmd_q);
      chk_q("copy_addr", {addr(12'h000, 17'h00020), addr(12'h000, 17'h00022)}, nand_dev_model_inst.addr_q);
      chk("copy_fail", 1, result.fail);
      fail_next <= 1'b0;
      run(nand_host_pkg::OP_RESET, 12'h000, 17'h00000);
      chk_q("reset_cmds", '{8'hFF}, nand_dev_model_inst.cmd_q);
   endtask
   task automatic print_verdict();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      t_refuse();
      t_read();
      t_cache();
      t_program();
      t_copy();
      print_verdict();
   end
   initial begin
      repeat (40000) @(posedge clk_sys);
      fails++;
      print_verdict();
   end
endmodule
bind nand_host_seq nand_seq_monitor nand_seq_monitor_inst (.clk_sys(clk_sys), .srst(srst), .rb_in(rb_in),
   .rd_valid(rd_valid), .pins(pins), .result(result));
`default_nettype wire
